//--- bpdp_pkg.sv
// Constants and types shared by the parallel BCD data port
//======================================================================
// Function
// - All display digits are driven at once as parallel BCD groups on open-collector outputs, never multiplexed.
// - The output carries the selected measurement result and refreshes only when a new measurement completes.
// - While the display is held, no new BCD output refresh starts; one already under way still completes.
// - Output polarity is selectable; positive turns the transistor on for an asserted bit, negative leaves it off.
// - Take-up inhibit is asserted while output data changes; the reader samples only while it is deasserted.
// - The active level of take-up inhibit is selectable by configuration.
// - Input data polarity is selectable (high active means pin open), and the sign line uses the opposite sense.
// - While the latch is in its inhibit state, capture stops and the last captured value is kept.
// - Latch polarity is selectable: inhibit when the pin is shorted to ground or, alternatively, when open.
package bpdp_pkg;

	//==================================================================
	// Geometry
	localparam int DIGITS = 5;
	localparam int DATA_W = DIGITS * 4;

	//==================================================================
	// Register map (byte addresses)
	localparam logic [11:0] CTRL_OFS    = 12'h000;
	localparam logic [11:0] MEAS_OFS    = 12'h004;
	localparam logic [11:0] OUT_OFS     = 12'h008;
	localparam logic [11:0] IN_OFS      = 12'h00C;
	localparam logic [11:0] STATUS_OFS  = 12'h010;

	// Control fields
	localparam int CTRL_OUT_POS_BIT  = 0;
	localparam int CTRL_TI_HIGH_BIT  = 1;
	localparam int CTRL_IN_HIGH_BIT  = 2;
	localparam int CTRL_LATCH_OPEN_BIT = 3;
	localparam int CTRL_HOLD_BIT     = 4;
	localparam logic [4:0] CTRL_RESET = 5'h01;

	//==================================================================
	// Take-up inhibit timing
	localparam int CLK_HZ       = 40_000_000;
	localparam int TI_SETUP_NS  = 1000;
	localparam int TI_HOLD_NS   = 1000;
	localparam int TI_SETUP_CYC = (TI_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int TI_HOLD_CYC  = (TI_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int CNT_W        = 8;

	//==================================================================
	// Output update sequencer
	typedef enum logic [2:0] {
		BPDP_IDLE  = 3'b001,
		BPDP_SETUP = 3'b010,
		BPDP_HOLD  = 3'b100
	} bpdp_state_type;

endpackage : bpdp_pkg

//--- bpdp_port.sv
// Parallel BCD data port: output side, input side and APB registers
`timescale 1ns/1ps
`default_nettype none
module bpdp_port
	import bpdp_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// Measurement source
	input  wire logic              meas_valid,
	input  wire logic [DATA_W-1:0] meas_digits,
	input  wire logic              meas_negative,
	// Output pins, level high means transistor conducting
	output var  logic [DATA_W-1:0] bcd_out_on,
	output var  logic              sign_out_on,
	output var  logic              take_up_inhibit_on,
	// Input pins, level high means pin open
	input  wire logic [DATA_W-1:0] bcd_in_open,
	input  wire logic              sign_in_open,
	input  wire logic              latch_in_open
);

	//==================================================================
	// Registers
	logic [4:0]        ctrl_reg;
	logic [DATA_W:0]   meas_reg;       // Sign on top, digits below
	logic              meas_new_reg;
	logic [DATA_W:0]   out_reg;
	logic [DATA_W:0]   in_reg;
	logic              ti_reg;
	logic [CNT_W-1:0]  cnt_reg;
	bpdp_state_type    state_reg;
	logic [DATA_W+1:0] pin_s1_reg;
	logic [DATA_W+1:0] pin_s2_reg;

	//==================================================================
	// Control decode
	wire out_pos    = ctrl_reg[CTRL_OUT_POS_BIT];
	wire ti_high    = ctrl_reg[CTRL_TI_HIGH_BIT];
	wire in_high    = ctrl_reg[CTRL_IN_HIGH_BIT];
	wire latch_open = ctrl_reg[CTRL_LATCH_OPEN_BIT];
	wire hold       = ctrl_reg[CTRL_HOLD_BIT];

	//==================================================================
	// APB address decode, one hit line per register
	wire hit_ctrl   = (paddr == CTRL_OFS);
	wire hit_meas   = (paddr == MEAS_OFS);
	wire hit_out    = (paddr == OUT_OFS);
	wire hit_in     = (paddr == IN_OFS);
	wire hit_status = (paddr == STATUS_OFS);
	wire mapped     = hit_ctrl | hit_meas | hit_out | hit_in | hit_status;

	// Setup phase starts the answer, access phase commits a write
	wire apb_setup = psel & ~penable;
	wire apb_wr    = psel & penable & pwrite;
	wire ctrl_wr   = apb_wr & hit_ctrl;     // Only control is writable

	//==================================================================
	// Input decode from synchronised pins
	wire [DATA_W-1:0] in_digits = in_high ? pin_s2_reg[DATA_W-1:0] : ~pin_s2_reg[DATA_W-1:0];
	wire              in_sign   = in_high ? ~pin_s2_reg[DATA_W] : pin_s2_reg[DATA_W];
	wire              latch_inh = latch_open ? pin_s2_reg[DATA_W+1] : ~pin_s2_reg[DATA_W+1];
	wire              ti_active = (state_reg != BPDP_IDLE);

	//==================================================================
	// Pin output next values, polarity applied ahead of the flop
	wire [DATA_W-1:0] bcd_out_next  = out_pos ? out_reg[DATA_W-1:0] : ~out_reg[DATA_W-1:0];
	wire              sign_out_next = out_pos ? out_reg[DATA_W] : ~out_reg[DATA_W];
	wire              ti_out_next   = ti_high ? ti_active : ~ti_active;

	// Pin outputs: registered so the open-collector drivers never glitch
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bcd_out_on         <= '0;
			sign_out_on        <= 1'b0;
			take_up_inhibit_on <= 1'b0;
		end else begin
			bcd_out_on         <= bcd_out_next;
			sign_out_on        <= sign_out_next;
			take_up_inhibit_on <= ti_out_next;
		end
	end

	//==================================================================
	// Two-flop synchroniser for all input pins
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else begin
			pin_s1_reg <= {latch_in_open, sign_in_open, bcd_in_open};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	//==================================================================
	// Input capture, frozen while the latch inhibits it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			in_reg <= '0;
		end else if (!latch_inh) begin
			in_reg <= {in_sign, in_digits};
		end
	end

	//==================================================================
	// Measurement catch: a new result waits for the sequencer; one arriving while held is dropped
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meas_reg     <= '0;
			meas_new_reg <= 1'b0;
		end else if (meas_valid) begin
			meas_reg     <= {meas_negative, meas_digits};
			meas_new_reg <= ~hold;
		end else if (state_reg == BPDP_IDLE && meas_new_reg) begin
			meas_new_reg <= 1'b0;
		end
	end

	//==================================================================
	// Sequencer conditions; a held display never starts a refresh
	wire seq_start = meas_new_reg & ~hold;
	wire cnt_zero  = (cnt_reg == '0);

	//==================================================================
	// Update sequencer: inhibit rises, data changes mid-window, inhibit falls
	// The window keeps a reader that samples late from seeing mixed digits
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= BPDP_IDLE;
			cnt_reg   <= '0;
			out_reg   <= '0;
		end else begin
			case (state_reg)
				BPDP_IDLE: begin
					if (seq_start) begin
						state_reg <= BPDP_SETUP;
						cnt_reg   <= CNT_W'(TI_SETUP_CYC - 1);
					end
				end
				BPDP_SETUP: begin
					if (cnt_zero) begin
						out_reg   <= meas_reg;
						state_reg <= BPDP_HOLD;
						cnt_reg   <= CNT_W'(TI_HOLD_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				BPDP_HOLD: begin
					if (cnt_zero) begin
						state_reg <= BPDP_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= BPDP_IDLE;
				end
			endcase
		end
	end

	//==================================================================
	// APB: zero-wait slave, unmapped addresses answer with an error
	// Status bits, all live views of internal state
	wire st_ti_active  = ti_active;
	wire st_hold_phase = (state_reg == BPDP_HOLD);
	wire st_pending    = meas_new_reg;
	wire st_latch_inh  = latch_inh;

	// Read words, zero extended to the bus width
	wire [31:0] rd_ctrl   = {27'h0, ctrl_reg};
	wire [31:0] rd_meas   = {11'h0, meas_reg};
	wire [31:0] rd_out    = {11'h0, out_reg};
	wire [31:0] rd_in     = {11'h0, in_reg};
	wire [31:0] rd_status = {28'h0, st_latch_inh, st_pending, st_hold_phase, st_ti_active};

	wire [31:0] rd_mux =
		hit_ctrl   ? rd_ctrl :
		hit_meas   ? rd_meas :
		hit_out    ? rd_out :
		hit_in     ? rd_in :
		hit_status ? rd_status :
		32'h0;

	// Answer next values: the answer stands for the access cycle only
	wire        pready_next  = apb_setup;
	wire        pslverr_next = apb_setup & ~mapped;
	wire [31:0] prdata_next  = (apb_setup & ~pwrite) ? rd_mux : 32'h0;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= pwdata[4:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= pready_next;
			pslverr <= pslverr_next;
			prdata  <= prdata_next;
		end
	end

endmodule : bpdp_port
`default_nettype wire

//--- bpdp_port_assertions.sv
// Port checker for the BCD data port
`timescale 1ns/1ps
`default_nettype none
module bpdp_port_assertions
	import bpdp_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              sys_rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [31:0]       prdata,
	input wire logic [DATA_W-1:0] bcd_out_on,
	input wire logic              take_up_inhibit_on
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	//==================================================================
	// Refresh not caused by a register write, which may flip polarity
	sequence upd;
		$changed(bcd_out_on) && !$past(psel) && !$past(psel, 2) && !$past(psel, 3);
	endsequence
	AST_READY: assert property (psel && !penable |=> pready) else $error("no answer");
	AST_SETUP: assert property (pready |-> $past(psel && !penable)) else $error("answer without setup");
	AST_ONCE: assert property (pready |=> !pready) else $error("ready held");
	AST_ERR: assert property (pslverr |-> pready && prdata == '0) else $error("bad error");
	AST_RDATA: assert property (!pready |-> prdata == '0) else $error("stray data");
	AST_RST: assert property ($fell(sys_rst) |-> bcd_out_on == '0) else $error("reset data");
	AST_TI_LEAD: assert property (upd |-> $past(take_up_inhibit_on, 40) != $past(take_up_inhibit_on, 41))
		else $error("inhibit lead");
	AST_TI_TAIL: assert property (upd |=> $stable(take_up_inhibit_on)[*8] ##32 $changed(take_up_inhibit_on))
		else $error("inhibit tail");
endmodule : bpdp_port_assertions
bind bpdp_port bpdp_port_assertions chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .bcd_out_on(bcd_out_on),
	.take_up_inhibit_on(take_up_inhibit_on));
`default_nettype wire

//--- bpdp_reader.sv
// Far-side reader of the BCD output
`timescale 1ns/1ps
`default_nettype none
module bpdp_reader
	import bpdp_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              ti_act,
	input wire logic [DATA_W-1:0] bcd_out_on,
	input wire logic              sign_out_on,
	input wire logic              take_up_inhibit_on,
	output var logic [DATA_W:0]   seen
);
	// Take data only while inhibit idles, so a half-changed word is never read
	always_ff @(posedge core_clk) begin
		if (take_up_inhibit_on != ti_act) seen <= {sign_out_on, bcd_out_on};
	end
endmodule : bpdp_reader
`default_nettype wire

//--- test_bcd_parallel_data_port.sv
// Bench for the BCD data port
`timescale 1ns/1ps
`default_nettype none
module test_bcd_parallel_data_port
	import bpdp_pkg::*;
;
	logic core_clk = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0, meas_valid = '0, meas_negative = '0;
	logic sign_in_open = '0, latch_in_open = '0, ti = '0, pready, pslverr, sign_out_on, take_up_inhibit_on, err, ng, s;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [DATA_W-1:0] meas_digits = '0, bcd_in_open = '0, bcd_out_on, d;
	logic [DATA_W:0] seen;
	int n_fail = 0, compares = 0, cyc = 0;
	bpdp_port dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas_valid(meas_valid), .meas_digits(meas_digits), .meas_negative(meas_negative),
		.bcd_out_on(bcd_out_on), .sign_out_on(sign_out_on), .take_up_inhibit_on(take_up_inhibit_on),
		.bcd_in_open(bcd_in_open), .sign_in_open(sign_in_open), .latch_in_open(latch_in_open));
	bpdp_reader rdr_u (.core_clk(core_clk), .ti_act(ti), .bcd_out_on(bcd_out_on), .sign_out_on(sign_out_on),
		.take_up_inhibit_on(take_up_inhibit_on), .seen(seen));
	initial forever #12.5 core_clk = ~core_clk;
	// Cut a hang short well past the expected run of about 1000 cycles
	always @(posedge core_clk) if (++cyc == 3000) begin n_fail++; end_sim(); end
	task automatic wt(input int n); repeat (n) @(posedge core_clk); endtask : wt
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end
	endtask : chk
	// One APB transfer; request held until pready is sampled high
	task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge core_clk);
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= v;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		rd = prdata; err = pslverr;
		psel <= 1'h0; penable <= 1'h0;
	endtask : ap
	function automatic logic [DATA_W-1:0] rbcd();
		for (int i = 0; i < DIGITS; i++) rbcd[4*i+:4] = 4'($urandom % 10);
	endfunction : rbcd
	task automatic meas(input logic [DATA_W-1:0] v);
		meas_digits <= v; meas_negative <= s; meas_valid <= 1'h1;
		@(posedge core_clk) meas_valid <= 1'h0;
	endtask : meas
	initial begin
		void'($urandom(32'hB046));
		wt(3);
		sys_rst <= 1'h0;
		ap(0, CTRL_OFS, '0); chk("ctrl", 32'h1, rd);
		ap(1, 12'h100, 32'hF); chk("slverr", 32'h1, 32'(err)); chk("rdata", '0, rd);
		$display("register test done");
		// Every pairing of data polarity and inhibit polarity
		for (int m = 0; m < 4; m++) begin
			ti = m[1]; ng = m[0]; d = rbcd(); s = 1'($urandom);
			ap(1, CTRL_OFS, {30'h0, ti, ~ng});
			wt(90);
			meas(d);
			wt(20);
			chk("ti_busy", 32'(ti), 32'(take_up_inhibit_on));
			wt(70);
			chk("bcd", 32'(d ^ {DATA_W{ng}}), 32'(bcd_out_on));
			chk("sign", 32'(s ^ ng), 32'(sign_out_on));
			chk("ti_idle", 32'(!ti), 32'(take_up_inhibit_on));
			chk("reader", 32'({s ^ ng, d ^ {DATA_W{ng}}}), 32'(seen));
		end
		$display("output test done");
		ap(1, CTRL_OFS, 32'h11);
		meas(rbcd());
		wt(90);
		chk("hold", 32'(d), 32'(bcd_out_on));
		chk("hold_ti", 32'h1, 32'(take_up_inhibit_on));
		$display("hold test done");
		// Each input sense with each latch sense
		for (int m = 0; m < 4; m++) begin
			d = rbcd(); s = 1'($urandom);
			ap(1, CTRL_OFS, {28'h0, 2'(m), 2'h1});
			bcd_in_open <= m[0] ? d : ~d; sign_in_open <= m[0] ? ~s : s; latch_in_open <= ~m[1];
			wt(6);
			latch_in_open <= m[1];
			wt(6);
			bcd_in_open <= rbcd(); sign_in_open <= ~sign_in_open;
			wt(6);
			ap(0, IN_OFS, '0); chk("capture", 32'({s, d}), rd);
		end
		$display("input test done");
		end_sim();
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
endmodule : test_bcd_parallel_data_port
`default_nettype wire
